// ==== verilog/opd_map.svh ====
// offsets, field positions and encodings for the operand decoder
`ifndef OPD_MAP_SVH
`define OPD_MAP_SVH
`define OPD_OPC_ADD_RR      8'h04
`define OPD_ESC_HI          4'hE
`define OPD_WREG_BASE_MSB   11
`define OPD_PAIR_LSB        0
`define OPD_BIT_W           3
`define OPD_ADDR16_W        16
`define OPD_ADDR12_W        12
`define OPD_RP_RESET        8'h00
`endif

// ==== verilog/opd_pkg.sv ====
// types shared by the operand decoder
package opd_pkg;
  typedef enum logic [3:0] {
    OPD_K_NONE,
    OPD_K_REG2,
    OPD_K_BIT,
    OPD_K_DIRECT,
    OPD_K_EXT,
    OPD_K_IMM,
    OPD_K_WPAIR,
    OPD_K_FPAIR,
    OPD_K_REL,
    OPD_K_INDEX,
    OPD_K_TRAP
  } opd_kind_e;

  typedef struct packed {
    logic        valid;
    logic        bad;
    logic [11:0] src;
    logic [11:0] dst;
    logic [15:0] addr;
    logic [7:0]  data;
    logic [2:0]  bitn;
    logic        pol;
  } opd_res_s;
endpackage

// ==== verilog/opd_decoder.sv ====
// operand field decoder for the 8-bit cpu instruction stream
`timescale 1ns/1ns
`include "opd_map.svh"

// Notes on behaviour
// - add 04: source byte first, destination second
// - register byte: any 0-255 or working register
// - byte E8 means working register 8
// - bit number three bits, positions 0-7
// - polarity is one bit, 0 or 1
// - direct address 16 bits, 0000-FFFF
// - extended register address 12 bits, 000-FFF
// - immediate byte used directly as data
// - working pair names even register only
// - file pair is even address 00-FE
// - relative offset signed, from next instruction
// - indexed adds signed byte to base
// - trap vector one byte 00-FF
module opd_decoder
  import opd_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        start,
  input  opd_kind_e        kind,
  input  wire logic        byte_valid,
  input  wire logic [7:0]  byte_in,
  input  wire logic [7:0]  reg_ptr,
  input  wire logic [15:0] next_pc,
  input  wire logic [11:0] base_addr,
  output logic             busy,
  output opd_res_s         result
);

  typedef enum {ST_IDLE, ST_B0, ST_B1, ST_DONE} opd_state_e;

  opd_state_e  st_q, st_d;
  opd_kind_e   kind_q, kind_d;
  logic [7:0]  b0_q, b0_d;
  logic        busy_q, busy_d;
  opd_res_s    res_q, res_d;

  // maps a register byte to a 12-bit file address, escaping E0-EF
  function automatic logic [11:0] reg_map(input logic [7:0] rb, input logic [7:0] rp);
    if (rb[7:4] == `OPD_ESC_HI)
      reg_map = {rp[7:4], rp[3:0], rb[3:0]};
    else
      reg_map = {4'h0, rb};
  endfunction

  // sign-extends a byte offset and adds it to a 16-bit base
  function automatic logic [15:0] sadd(input logic [15:0] base, input logic [7:0] off);
    sadd = 16'(base + {{8{off[7]}}, off});
  endfunction

  // operand byte sequencing and field decode
  always_comb begin
    st_d   = st_q;
    kind_d = kind_q;
    b0_d   = b0_q;
    busy_d = busy_q;
    res_d  = res_q;
    res_d.valid = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (start) begin
          kind_d = kind;
          busy_d = 1'b1;
          st_d   = ST_B0;
        end
      end
      ST_B0: begin
        if (byte_valid) begin
          b0_d = byte_in;
          res_d = '0;
          case (kind_q)
            OPD_K_REG2, OPD_K_DIRECT, OPD_K_EXT: st_d = ST_B1;
            OPD_K_BIT: begin
              res_d.bitn = byte_in[`OPD_BIT_W-1:0];
              res_d.pol  = byte_in[`OPD_BIT_W];
              st_d = ST_DONE;
            end
            OPD_K_IMM: begin
              res_d.data = byte_in;
              st_d = ST_DONE;
            end
            OPD_K_TRAP: begin
              res_d.addr = {8'h00, byte_in};
              st_d = ST_DONE;
            end
            OPD_K_WPAIR: begin
              res_d.dst = reg_map({`OPD_ESC_HI, byte_in[3:0]}, reg_ptr);
              res_d.bad = byte_in[`OPD_PAIR_LSB];
              st_d = ST_DONE;
            end
            OPD_K_FPAIR: begin
              res_d.dst = reg_map(byte_in, reg_ptr);
              res_d.bad = byte_in[`OPD_PAIR_LSB];
              st_d = ST_DONE;
            end
            OPD_K_REL: begin
              res_d.addr = sadd(next_pc, byte_in);
              st_d = ST_DONE;
            end
            OPD_K_INDEX: begin
              res_d.dst = 12'(sadd({4'h0, base_addr}, byte_in));
              st_d = ST_DONE;
            end
            default: st_d = ST_DONE;
          endcase
        end
      end
      ST_B1: begin
        if (byte_valid) begin
          case (kind_q)
            OPD_K_REG2: begin
              res_d.src = reg_map(b0_q, reg_ptr);
              res_d.dst = reg_map(byte_in, reg_ptr);
            end
            OPD_K_DIRECT: res_d.addr = {b0_q, byte_in};
            OPD_K_EXT: res_d.dst = {b0_q, byte_in[7:4]};
            default: res_d.bad = 1'b1;
          endcase
          st_d = ST_DONE;
        end
      end
      ST_DONE: begin
        res_d.valid = 1'b1;
        busy_d = 1'b0;
        st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_q   <= ST_IDLE;
      kind_q <= OPD_K_NONE;
      b0_q   <= 8'h00;
      busy_q <= 1'b0;
      res_q  <= '0;
    end else begin
      st_q   <= st_d;
      kind_q <= kind_d;
      b0_q   <= b0_d;
      busy_q <= busy_d;
      res_q  <= res_d;
    end
  end

  assign busy   = busy_q;
  assign result = res_q;

  // a decode request taken while idle
  sequence s_start_taken;
    st_q == ST_IDLE && start;
  endsequence

  // the only byte of a one-byte operand taken
  sequence s_last_one;
    st_q == ST_B0 && byte_valid && !(kind_q inside {OPD_K_REG2, OPD_K_DIRECT, OPD_K_EXT});
  endsequence

  // the second byte of a two-byte operand taken
  sequence s_last_two;
    st_q == ST_B1 && byte_valid;
  endsequence

  // fields settle first, then one valid pulse as busy drops
  sequence s_finish;
    !res_q.valid && busy_q ##1 res_q.valid && !busy_q;
  endsequence

  // escaped source byte maps through the pointer
  chk_reg_escape: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == ST_B1 && byte_valid && kind_q == OPD_K_REG2 && b0_q[7:4] == 4'hE)
      |=> res_q.src[3:0] == $past(b0_q[3:0]) && res_q.src[11:4] == $past(reg_ptr))
    else $error("escaped source not mapped");

  // plain destination byte is a file address
  chk_reg_plain: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == ST_B1 && byte_valid && kind_q == OPD_K_REG2 && byte_in[7:4] != 4'hE)
      |=> res_q.dst == {4'h0, $past(byte_in)})
    else $error("plain destination not mapped");

  // escaped destination byte maps through the pointer
  chk_dst_escape: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == ST_B1 && byte_valid && kind_q == OPD_K_REG2 && byte_in[7:4] == 4'hE)
      |=> res_q.dst == {$past(reg_ptr), $past(byte_in[3:0])})
    else $error("escaped destination not mapped");

  // first byte after the opcode is the source
  chk_src_first: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == ST_B1 && byte_valid && kind_q == OPD_K_REG2 && b0_q[7:4] != 4'hE)
      |=> res_q.src == {4'h0, $past(b0_q)})
    else $error("source byte not first");

  // two-byte kinds wait for their second byte
  chk_second_wait: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == ST_B0 && byte_valid && kind_q inside {OPD_K_REG2, OPD_K_DIRECT, OPD_K_EXT})
      |=> st_q == ST_B1 && busy_q && !res_q.valid)
    else $error("second byte not awaited");

  // bit number and polarity fields
  chk_bit_field: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == ST_B0 && byte_valid && kind_q == OPD_K_BIT)
      |=> res_q.bitn == $past(byte_in[2:0]) && res_q.pol == $past(byte_in[3]))
    else $error("bit or polarity wrong");

  // direct address high byte first, then valid
  chk_direct_addr: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == ST_B1 && byte_valid && kind_q == OPD_K_DIRECT)
      |=> res_q.addr == {$past(b0_q), $past(byte_in)} ##1 res_q.valid)
    else $error("direct address wrong");

  // extended address spans twelve bits
  chk_ext_addr: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == ST_B1 && byte_valid && kind_q == OPD_K_EXT)
      |=> res_q.dst == {$past(b0_q), $past(byte_in[7:4])})
    else $error("extended address wrong");

  // immediate passes through as data
  chk_imm_data: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == ST_B0 && byte_valid && kind_q == OPD_K_IMM) |=> res_q.data == $past(byte_in))
    else $error("immediate wrong");

  // bit, immediate, trap, relative and indexed kinds never raise the odd flag
  chk_bad_clear: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == ST_B0 && byte_valid && kind_q inside {OPD_K_BIT, OPD_K_IMM, OPD_K_TRAP, OPD_K_REL, OPD_K_INDEX})
      |=> !res_q.bad)
    else $error("odd flag raised without pair");

  // odd pair bytes are flagged
  chk_pair_even: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == ST_B0 && byte_valid && (kind_q == OPD_K_WPAIR || kind_q == OPD_K_FPAIR))
      |=> res_q.bad == $past(byte_in[0]))
    else $error("odd pair not flagged");

  // working pair uses the low nibble through the pointer
  chk_wpair_reg: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == ST_B0 && byte_valid && kind_q == OPD_K_WPAIR)
      |=> res_q.dst == {$past(reg_ptr), $past(byte_in[3:0])})
    else $error("working pair wrong");

  // plain file pair byte is a file address
  chk_fpair_plain: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == ST_B0 && byte_valid && kind_q == OPD_K_FPAIR && byte_in[7:4] != 4'hE)
      |=> res_q.dst == {4'h0, $past(byte_in)})
    else $error("file pair wrong");

  // relative target counts from the next instruction
  chk_rel_target: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == ST_B0 && byte_valid && kind_q == OPD_K_REL)
      |=> res_q.addr == 16'($past(next_pc) + {{8{$past(byte_in[7])}}, $past(byte_in)}))
    else $error("relative target wrong");

  // relative operand touches no register field
  chk_rel_regs: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == ST_B0 && byte_valid && kind_q == OPD_K_REL)
      |=> res_q.src == 12'h000 && res_q.dst == 12'h000)
    else $error("relative operand set a register");

  // indexed address adds the signed byte
  chk_index_addr: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == ST_B0 && byte_valid && kind_q == OPD_K_INDEX)
      |=> res_q.dst == 12'($past(base_addr) + {{4{$past(byte_in[7])}}, $past(byte_in)}))
    else $error("indexed address wrong");

  // trap vector fills the low address byte
  chk_trap_vec: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == ST_B0 && byte_valid && kind_q == OPD_K_TRAP) |=> res_q.addr == {8'h00, $past(byte_in)})
    else $error("trap vector wrong");

  // escaped file pair byte maps through the pointer
  chk_escape_range: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == ST_B0 && byte_valid && kind_q == OPD_K_FPAIR && byte_in[7:4] == 4'hE)
      |=> res_q.dst == {$past(reg_ptr), $past(byte_in[3:0])})
    else $error("escape range wrong");

  // a taken request raises busy and latches the kind
  chk_busy_start: assert property (@(posedge mclk) disable iff (!rstn)
    s_start_taken |=> busy_q && st_q == ST_B0 && kind_q == $past(kind))
    else $error("request not taken");

  // a request while busy leaves the kind alone
  chk_start_ignored: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q != ST_IDLE && start) |=> kind_q == $past(kind_q))
    else $error("request taken while busy");

  // one-byte operands finish two edges after their byte
  chk_one_byte_end: assert property (@(posedge mclk) disable iff (!rstn)
    s_last_one |=> s_finish)
    else $error("one-byte operand did not finish");

  // two-byte operands finish two edges after the last byte
  chk_two_byte_end: assert property (@(posedge mclk) disable iff (!rstn)
    s_last_two |=> s_finish)
    else $error("two-byte operand did not finish");

  // valid stands for a single cycle
  chk_valid_pulse: assert property (@(posedge mclk) disable iff (!rstn)
    res_q.valid |=> !res_q.valid)
    else $error("valid longer than one cycle");

  // reset leaves the decoder idle with no result pulse
  chk_reset_idle: assert property (@(posedge mclk)
    !rstn |=> st_q == ST_IDLE && !busy_q && !res_q.valid)
    else $error("decoder not idle after reset");

endmodule // opd_decoder

// ==== sim/opd_prog_mem.sv ====
// program memory model feeding operand bytes to the decoder
`timescale 1ns/1ns
module opd_prog_mem (
  input  wire logic       mclk,
  input  wire logic       busy,
  input  wire logic [1:0] n,
  input  wire logic [7:0] b1,
  input  wire logic [7:0] b2,
  output logic            byte_valid,
  output logic [7:0]      byte_in
);
  logic [1:0] idx;
  // hands out the operand bytes in object-code order while a decode runs
  always @(negedge mclk) begin
    if (busy && idx < n) begin
      byte_valid <= 1'b1;
      byte_in    <= (idx == 2'h0) ? b1 : b2;
      idx        <= idx + 2'h1;
    end else begin
      byte_valid <= 1'b0;
      byte_in    <= ~byte_in; // released bus keeps moving
      if (!busy) idx <= 2'h0;
    end
  end
  // idle bus at time zero
  initial begin
    byte_valid = 1'b0;
    byte_in    = 8'h00;
    idx        = 2'h0;
  end
endmodule // opd_prog_mem

// ==== sim/cpu_operand_encoding_bench.sv ====
// self-checking bench for the operand decoder
`timescale 1ns/1ns
module cpu_operand_encoding_bench;
  import opd_pkg::*;
  logic        mclk = 1'b0, rstn = 1'b0, start = 1'b0, byte_valid, busy;
  logic [7:0]  byte_in, b1 = 8'h00, b2 = 8'h00, reg_ptr = 8'h12;
  logic [1:0]  n = 2'h0;
  logic [15:0] next_pc = 16'h1000;
  logic [11:0] base_addr = 12'h100;
  opd_kind_e   kind = OPD_K_NONE;
  opd_res_s    result;
  int          n_fail = 0, num_checks = 0, cyc = 0;

  opd_decoder i_dut (.mclk(mclk), .rstn(rstn), .start(start), .kind(kind), .byte_valid(byte_valid),
    .byte_in(byte_in), .reg_ptr(reg_ptr), .next_pc(next_pc), .base_addr(base_addr), .busy(busy),
    .result(result));
  opd_prog_mem i_mem (.mclk(mclk), .busy(busy), .n(n), .b1(b1), .b2(b2), .byte_valid(byte_valid),
    .byte_in(byte_in));

  // clock and hang guard
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one decode: start, let memory feed c bytes, wait for the result pulse
  task automatic dec(input opd_kind_e k, input logic [1:0] c, input logic [7:0] x, input logic [7:0] y);
    int i;
    @(negedge mclk);
    start = 1'b1; kind = k; n = c; b1 = x; b2 = y;
    @(negedge mclk);
    start = 1'b0;
    for (i = 0; i < 8 && result.valid !== 1'b1; i++) @(negedge mclk);
    chk(result.valid, 16'h0001);
    chk(busy, 16'h0000);
  endtask

  task automatic t_reg2();
    dec(OPD_K_REG2, 2'h2, 8'h08, 8'h43);
    chk(result.src, 16'h0008);
    chk(result.dst, 16'h0043);
    dec(OPD_K_REG2, 2'h2, 8'hE8, 8'hFF);
    chk(result.src, {reg_ptr, 4'h8});
    chk(result.dst, 16'h00FF);
  endtask

  task automatic t_bit();
    dec(OPD_K_BIT, 2'h1, 8'h07, 8'h00);
    chk(result.bitn, 16'h0007);
    chk(result.pol, 16'h0000);
    dec(OPD_K_BIT, 2'h1, 8'h08, 8'h00);
    chk(result.bitn, 16'h0000);
    chk(result.pol, 16'h0001);
  endtask

  task automatic t_addr();
    dec(OPD_K_DIRECT, 2'h2, 8'hFF, 8'hFE);
    chk(result.addr, 16'hFFFE);
    dec(OPD_K_EXT, 2'h2, 8'hAB, 8'hC0);
    chk(result.dst, 16'h0ABC);
    dec(OPD_K_IMM, 2'h1, 8'hFF, 8'h00);
    chk(result.data, 16'h00FF);
    dec(OPD_K_TRAP, 2'h1, 8'hFF, 8'h00);
    chk(result.addr, 16'h00FF);
  endtask

  task automatic t_pair();
    dec(OPD_K_WPAIR, 2'h1, 8'hE6, 8'h00);
    chk(result.bad, 16'h0000);
    chk(result.dst, {reg_ptr, 4'h6});
    dec(OPD_K_WPAIR, 2'h1, 8'hE7, 8'h00);
    chk(result.bad, 16'h0001);
    dec(OPD_K_FPAIR, 2'h1, 8'hFE, 8'h00);
    chk(result.bad, 16'h0000);
    chk(result.dst, 16'h00FE);
    dec(OPD_K_FPAIR, 2'h1, 8'h41, 8'h00);
    chk(result.bad, 16'h0001);
  endtask

  task automatic t_off();
    dec(OPD_K_REL, 2'h1, 8'h80, 8'h00);
    chk(result.addr, 16'h0F80);
    dec(OPD_K_REL, 2'h1, 8'h7F, 8'h00);
    chk(result.addr, 16'h107F);
    dec(OPD_K_INDEX, 2'h1, 8'hFF, 8'h00);
    chk(result.dst, 16'h00FF);
    dec(OPD_K_INDEX, 2'h1, 8'h7F, 8'h00);
    chk(result.dst, 16'h017F);
  endtask

  // reset for 4 cycles, then each scenario in turn
  initial begin
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    rstn = 1'b1;
    chk(result.addr, 16'h0000);
    chk(result.valid, 16'h0000);
    t_reg2();
    t_bit();
    t_addr();
    t_pair();
    t_off();
    end_sim();
  end
endmodule // cpu_operand_encoding_bench
